// ===== logic/rfr_pkg.sv
`default_nettype none
package rfr_pkg;
	localparam logic [7:0] ADDR_MINUTES = 8'h02;
	localparam logic [7:0] ADDR_FLAGS = 8'h2b;
	localparam logic [7:0] ADDR_RESET = 8'h2f;
	localparam logic [7:0] ADDR_TS_FIRST = 8'h11;
	localparam logic [7:0] ADDR_TS_LAST = 8'h22;
	localparam int TS_BYTES = 18;
	localparam logic [7:0] CMD_SOFT_RESET = 8'h2c;
	localparam logic [7:0] CMD_PRESCALER_CLEAR = 8'ha4;
	localparam logic [7:0] CMD_CAPTURE_CLEAR = 8'h25;
	localparam logic [7:0] CMD_BOTH_CLEAR = 8'ha5;
	localparam int FLAG_PERIODIC = 7;
	localparam int FLAG_ALARM2 = 6;
	localparam int FLAG_ALARM1 = 5;
	localparam int FLAG_SUPERVISOR = 4;
	localparam int FLAG_SWITCHOVER = 3;
	localparam int FLAG_CAPTURE3 = 2;
	localparam int FLAG_CAPTURE2 = 1;
	localparam int FLAG_CAPTURE1 = 0;
	localparam logic [7:0] FLAGS_RESET = 8'h00;
	localparam logic [6:0] MINUTES_RESET = 7'h00;
	localparam logic [7:0] DEF_SECONDS = 8'h80;
	localparam logic [7:0] DEF_DAYS = 8'h01;
	localparam logic [7:0] DEF_WEEKDAY = 8'h06;
	localparam logic [7:0] DEF_MONTHS = 8'h01;
	localparam logic [7:0] DEF_ZERO = 8'h00;
	localparam logic [2:0] DEF_CLK_SEL = 3'h0;
	localparam logic [1:0] POR_HOLD = 2'h3;
endpackage : rfr_pkg
`default_nettype wire

// ===== logic/rfr_capture_mem.sv
`default_nettype none
module rfr_capture_mem
	import rfr_pkg::*;
(
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic clear_i,
	input wire logic we_i,
	input wire logic [4:0] waddr_i,
	input wire logic [7:0] wdata_i,
	input wire logic [4:0] raddr_i,
	output logic [7:0] rdata_o
);
	logic [7:0] mem_q [TS_BYTES];

	// Clear wins over a simultaneous capture write
	for (genvar i = 0; i < TS_BYTES; i++) begin : g_byte
		always_ff @(posedge clk_i or negedge rstn_i) begin
			if (!rstn_i) begin
				mem_q[i] <= 8'h00;
			end else if (clear_i) begin
				mem_q[i] <= 8'h00;
			end else if (we_i && waddr_i == 5'(i)) begin
				mem_q[i] <= wdata_i;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rdata_o <= 8'h00;
		end else if (raddr_i < 5'(TS_BYTES)) begin
			rdata_o <= mem_q[raddr_i];
		end else begin
			rdata_o <= 8'h00;
		end
	end
endmodule : rfr_capture_mem
`default_nettype wire

// ===== logic/rfr_cmd_decode.sv
`default_nettype none
module rfr_cmd_decode
	import rfr_pkg::*;
(
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic wr_i,
	input wire logic [7:0] wdata_i,
	output logic soft_reset_o,
	output logic prescaler_clear_o,
	output logic capture_clear_o
);
	logic is_sr, is_cpr, is_cts, is_both;

	always_comb begin
		is_sr = wr_i && wdata_i == CMD_SOFT_RESET;
		is_cpr = wr_i && wdata_i == CMD_PRESCALER_CLEAR;
		is_cts = wr_i && wdata_i == CMD_CAPTURE_CLEAR;
		is_both = wr_i && wdata_i == CMD_BOTH_CLEAR;
	end

	// One-cycle strobes, nothing held after the write
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			soft_reset_o <= 1'b0;
			prescaler_clear_o <= 1'b0;
			capture_clear_o <= 1'b0;
		end else begin
			soft_reset_o <= is_sr;
			prescaler_clear_o <= is_sr || is_cpr || is_both;
			capture_clear_o <= is_sr || is_cts || is_both;
		end
	end
endmodule : rfr_cmd_decode
`default_nettype wire

// ===== logic/rfr_flags_top.sv
// Functional notes
// - Bit 7 holds periodic event flag; write 0 clears, 1 keeps.
// - Bit 6 holds second alarm flag; write 0 clears, 1 keeps.
// - Bit 5 holds first alarm flag; write 0 clears, 1 keeps.
// - Bit 4 holds supervisor timeout flag; write 0 clears, 1 keeps.
// - Bit 3 holds supply switchover flag; write 0 clears, 1 keeps.
// - Bit 2 holds capture three flag; write 0 clears, 1 keeps.
// - Bit 1 holds capture two flag; write 0 clears, 1 keeps.
// - Bit 0 holds capture one flag; write 0 clears, 1 keeps.
// - Flags set by their source, stay set until software clears.
// - Flag write stores written byte ANDed with current flags.
// - OR of flags reads as minutes register MSB.
// - Byte 2Ch to reset register 2Fh performs soft reset.
// - Soft reset also clears prescaler and capture registers.
// - Byte A4h clears the prescaler.
// - Byte 25h clears the capture registers.
// - Byte A5h clears prescaler and capture registers together.
// - Any other reset register byte does nothing.
// - Power-on generates a reset equal to soft reset; here it gives every soft reset strobe except soft_reset_o.
// - Reset: calendar mode, hundredths off, 00:00:00.00, 2000.01.01, Saturday.
// - Reset: switchover enabled, lower threshold.
// - Reset: irq pin and clock pin give 32 kHz, capture input off.
// - Capture clear zeroes timestamp registers 11h to 22h.
`default_nettype none
module rfr_flags_top
	import rfr_pkg::*;
(
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	output logic [7:0] rdata_o,
	output logic rvalid_o,
	input wire logic [7:0] flag_set_i,
	input wire logic [6:0] minutes_i,
	input wire logic ts_we_i,
	input wire logic [4:0] ts_waddr_i,
	input wire logic [7:0] ts_wdata_i,
	output logic [7:0] flags_o,
	output logic event_monitor_o,
	output logic soft_reset_o,
	output logic prescaler_clear_o,
	output logic capture_clear_o,
	output logic defaults_load_o,
	output logic [7:0] def_seconds_o,
	output logic [7:0] def_days_o,
	output logic [7:0] def_weekday_o,
	output logic [7:0] def_months_o,
	output logic [7:0] def_years_o,
	output logic stopwatch_mode_o,
	output logic hundredths_en_o,
	output logic switchover_en_o,
	output logic switchover_high_thr_o,
	output logic [2:0] irq_pin_clk_sel_o,
	output logic [2:0] clk_pin_sel_o,
	output logic capture_input_en_o
);
	logic [7:0] flags_q, flags_d;
	logic flag_wr, reset_wr, minutes_rd, ts_rd;
	logic [1:0] por_cnt_q;
	logic por_pulse_q;
	logic sr_strobe, cpr_strobe, cts_strobe;
	logic [7:0] ts_rdata;
	logic [4:0] ts_raddr;
	logic rd_pend_q;
	logic [7:0] rd_addr_q;

	assign flag_wr = wr_i && addr_i == ADDR_FLAGS;
	assign reset_wr = wr_i && addr_i == ADDR_RESET;
	assign ts_raddr = 5'(addr_i - ADDR_TS_FIRST);

	rfr_cmd_decode u_cmd (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.wr_i(reset_wr),
		.wdata_i(wdata_i),
		.soft_reset_o(sr_strobe),
		.prescaler_clear_o(cpr_strobe),
		.capture_clear_o(cts_strobe)
	);

	// Power-on reset: a short strobe after release, loads defaults and clears like soft reset, but no soft_reset_o
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			por_cnt_q <= 2'h0;
			por_pulse_q <= 1'b0;
		end else begin
			por_pulse_q <= por_cnt_q == POR_HOLD - 2'h1;
			if (por_cnt_q != POR_HOLD) begin
				por_cnt_q <= por_cnt_q + 2'h1;
			end
		end
	end

	rfr_capture_mem u_ts (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.clear_i(cts_strobe || por_pulse_q),
		.we_i(ts_we_i),
		.waddr_i(ts_waddr_i),
		.wdata_i(ts_wdata_i),
		.raddr_i(ts_raddr),
		.rdata_o(ts_rdata)
	);

	// Set wins over a clear in the same cycle, so no event is lost
	always_comb begin
		flags_d = flags_q;
		if (flag_wr) begin
			flags_d = flags_q & wdata_i;
		end
		flags_d = flags_d | flag_set_i;
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			flags_q <= FLAGS_RESET;
		end else begin
			flags_q <= flags_d;
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			flags_o <= FLAGS_RESET;
			event_monitor_o <= 1'b0;
		end else begin
			flags_o <= flags_d;
			event_monitor_o <= |flags_d;
		end
	end

	// Read port: data two cycles after the read request
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rd_pend_q <= 1'b0;
			rd_addr_q <= 8'h00;
		end else begin
			rd_pend_q <= rd_i;
			rd_addr_q <= addr_i;
		end
	end

	assign minutes_rd = rd_addr_q == ADDR_MINUTES;
	assign ts_rd = rd_addr_q >= ADDR_TS_FIRST && rd_addr_q <= ADDR_TS_LAST;

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rdata_o <= 8'h00;
			rvalid_o <= 1'b0;
		end else begin
			rvalid_o <= rd_pend_q;
			if (!rd_pend_q) begin
				rdata_o <= 8'h00;
			end else if (minutes_rd) begin
				rdata_o <= {|flags_q, minutes_i};
			end else if (rd_addr_q == ADDR_FLAGS) begin
				rdata_o <= flags_q;
			end else if (ts_rd) begin
				rdata_o <= ts_rdata;
			end else begin
				rdata_o <= 8'h00;
			end
		end
	end

	// Command strobes out; soft reset and power-on both load defaults
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			soft_reset_o <= 1'b0;
			prescaler_clear_o <= 1'b0;
			capture_clear_o <= 1'b0;
			defaults_load_o <= 1'b0;
		end else begin
			soft_reset_o <= sr_strobe;
			prescaler_clear_o <= cpr_strobe || por_pulse_q;
			capture_clear_o <= cts_strobe || por_pulse_q;
			defaults_load_o <= sr_strobe || por_pulse_q;
		end
	end

	// Default configuration presented for the load strobe
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			def_seconds_o <= DEF_SECONDS;
			def_days_o <= DEF_DAYS;
			def_weekday_o <= DEF_WEEKDAY;
			def_months_o <= DEF_MONTHS;
			def_years_o <= DEF_ZERO;
			stopwatch_mode_o <= 1'b0;
			hundredths_en_o <= 1'b0;
			switchover_en_o <= 1'b1;
			switchover_high_thr_o <= 1'b0;
			irq_pin_clk_sel_o <= DEF_CLK_SEL;
			clk_pin_sel_o <= DEF_CLK_SEL;
			capture_input_en_o <= 1'b0;
		end else begin
			def_seconds_o <= DEF_SECONDS;
			def_days_o <= DEF_DAYS;
			def_weekday_o <= DEF_WEEKDAY;
			def_months_o <= DEF_MONTHS;
			def_years_o <= DEF_ZERO;
			stopwatch_mode_o <= 1'b0;
			hundredths_en_o <= 1'b0;
			switchover_en_o <= 1'b1;
			switchover_high_thr_o <= 1'b0;
			irq_pin_clk_sel_o <= DEF_CLK_SEL;
			clk_pin_sel_o <= DEF_CLK_SEL;
			capture_input_en_o <= 1'b0;
		end
	end

	a_flag_and_write: assert property (@(posedge clk_i) disable iff (!rstn_i)
		flag_wr |=> flags_q == (($past(flags_q) & $past(wdata_i)) | $past(flag_set_i)))
		else $error("flag write not AND merged");
	a_flag_sticky: assert property (@(posedge clk_i) disable iff (!rstn_i)
		!flag_wr |=> (flags_q & $past(flags_q)) == $past(flags_q))
		else $error("flag cleared without write");
	a_set_beats_clear: assert property (@(posedge clk_i) disable iff (!rstn_i)
		flag_set_i[FLAG_PERIODIC] |=> flags_q[FLAG_PERIODIC])
		else $error("set lost");
	a_monitor_or: assert property (@(posedge clk_i) disable iff (!rstn_i)
		event_monitor_o == |flags_q)
		else $error("event monitor mismatch");
	a_sr_strobe: assert property (@(posedge clk_i) disable iff (!rstn_i)
		reset_wr && wdata_i == CMD_SOFT_RESET |-> ##2 soft_reset_o && prescaler_clear_o && capture_clear_o)
		else $error("soft reset actions missing");
	a_cpr_only: assert property (@(posedge clk_i) disable iff (!rstn_i)
		reset_wr && wdata_i == CMD_PRESCALER_CLEAR |-> ##2 prescaler_clear_o && !soft_reset_o)
		else $error("prescaler clear wrong");
	a_cts_only: assert property (@(posedge clk_i) disable iff (!rstn_i)
		reset_wr && wdata_i == CMD_CAPTURE_CLEAR |-> ##2 capture_clear_o && !soft_reset_o)
		else $error("capture clear wrong");
	a_both_clear: assert property (@(posedge clk_i) disable iff (!rstn_i)
		reset_wr && wdata_i == CMD_BOTH_CLEAR |-> ##2 prescaler_clear_o && capture_clear_o && !soft_reset_o)
		else $error("combined clear wrong");
	a_no_stray_cmd: assert property (@(posedge clk_i) disable iff (!rstn_i)
		!reset_wr && !por_pulse_q |-> ##2 !soft_reset_o)
		else $error("stray soft reset");
	a_strobe_single: assert property (@(posedge clk_i) disable iff (!rstn_i)
		soft_reset_o && !$past(reset_wr, 1) |=> !soft_reset_o)
		else $error("soft reset strobe held");
endmodule : rfr_flags_top
`default_nettype wire

// ===== tb/rfr_host_model.sv
`default_nettype none
module rfr_host_model (
	input wire logic clk_i,
	output logic wr_o,
	output logic rd_o,
	output logic [7:0] addr_o,
	output logic [7:0] wdata_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		wr_o = 1'b0;
		rd_o = 1'b0;
		addr_o = 8'h00;
		wdata_o = 8'h00;
	end
	// Released address and data lines show the inverse, so stale values cannot pass
	task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		wr_o <= w;
		rd_o <= !w;
		addr_o <= a;
		wdata_o <= d;
		@(posedge clk_i);
		wr_o <= 1'b0;
		rd_o <= 1'b0;
		addr_o <= ~a;
		wdata_o <= ~d;
	endtask : access
endmodule : rfr_host_model
`default_nettype wire

// ===== tb/testbench.sv
`default_nettype none
module testbench;
	import rfr_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic ts_we_i = 1'b0;
	logic wr, rd, rvalid_o, ev_o, sr_o, pc_o, cc_o, dl_o, sw_mode, hund, sw_en, sw_hi, cap_en;
	logic [7:0] addr, wdata, rdata_o, flags_o, d_sec, d_day, d_wd, d_mon, d_yr, ef;
	logic [7:0] flag_set_i = 8'h00;
	logic [7:0] ts_wdata_i = 8'h00;
	logic [6:0] minutes_i = 7'h2a;
	logic [4:0] ts_waddr_i = 5'h00;
	logic [2:0] irq_sel, clk_sel;
	logic [31:0] lf = 32'h42c129b7;
	logic [8:0] q[$];
	logic [8:0] e;
	int mismatches = 0;
	int checks = 0;
	int cycles = 0;
	logic [7:0] cmd[7] = '{8'h2c, 8'ha4, 8'h25, 8'ha5, 8'h2d, 8'h00, 8'hff};
	logic [7:0] code[7] = '{8'h0f, 8'h02, 8'h01, 8'h03, 8'h00, 8'h00, 8'h00};

	rfr_host_model u_rfr_host_model (.clk_i(clk_i), .wr_o(wr), .rd_o(rd), .addr_o(addr), .wdata_o(wdata));
	rfr_flags_top u_rfr_flags_top (.clk_i(clk_i), .rstn_i(rstn_i), .wr_i(wr), .rd_i(rd), .addr_i(addr),
		.wdata_i(wdata), .rdata_o(rdata_o), .rvalid_o(rvalid_o), .flag_set_i(flag_set_i),
		.minutes_i(minutes_i), .ts_we_i(ts_we_i), .ts_waddr_i(ts_waddr_i), .ts_wdata_i(ts_wdata_i),
		.flags_o(flags_o), .event_monitor_o(ev_o), .soft_reset_o(sr_o), .prescaler_clear_o(pc_o),
		.capture_clear_o(cc_o), .defaults_load_o(dl_o), .def_seconds_o(d_sec), .def_days_o(d_day),
		.def_weekday_o(d_wd), .def_months_o(d_mon), .def_years_o(d_yr), .stopwatch_mode_o(sw_mode),
		.hundredths_en_o(hund), .switchover_en_o(sw_en), .switchover_high_thr_o(sw_hi),
		.irq_pin_clk_sel_o(irq_sel), .clk_pin_sel_o(clk_sel), .capture_input_en_o(cap_en));

	initial begin
		forever #4 clk_i = ~clk_i;
	end

	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr_next

	task automatic check(input string n, input logic [8:0] x, input logic [8:0] g);
		checks++;
		if (g !== x) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", n, x, g);
		end
	endtask : check

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : print_verdict

	task automatic rd_exp(input logic [7:0] a, input logic [7:0] x);
		q.push_back({1'b1, x});
		u_rfr_host_model.access(1'b0, a, 8'h00);
	endtask : rd_exp

	// Strobe code is {defaults, soft, prescaler, capture}; zero means none expected
	task automatic wr_exp(input logic [7:0] a, input logic [7:0] d, input logic [7:0] c);
		if (c != 8'h00) q.push_back({1'b0, c});
		u_rfr_host_model.access(1'b1, a, d);
	endtask : wr_exp

	task automatic pulse(input logic [7:0] v, input logic we, input logic [4:0] ta);
		@(posedge clk_i);
		flag_set_i <= v;
		ts_we_i <= we;
		ts_waddr_i <= ta;
		ts_wdata_i <= v;
		@(posedge clk_i);
		flag_set_i <= 8'h00;
		ts_we_i <= 1'b0;
	endtask : pulse

	// A strobe with no note left, or a repeated one, is caught here
	always @(posedge clk_i) begin
		if (rstn_i && (rvalid_o === 1'b1 || {dl_o, sr_o, pc_o, cc_o} !== 4'h0)) begin
			e = (q.size() > 0) ? q.pop_front() : 9'h1ff;
			check("result", e, {rvalid_o, rvalid_o ? rdata_o : {4'h0, dl_o, sr_o, pc_o, cc_o}});
		end
	end

	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 4000) begin
			mismatches++;
			print_verdict();
		end
	end

	initial begin
		q.push_back({1'b0, 8'h0b});
		repeat (8) @(posedge clk_i);
		rstn_i <= 1'b1;
		repeat (6) @(posedge clk_i);
		check("seconds", {1'b0, DEF_SECONDS}, {1'b0, d_sec});
		check("date", 9'h101, {d_day[0], d_mon});
		check("weekday_year", 9'h060, {1'b0, d_wd[3:0], d_yr[3:0]});
		check("mode", 9'h000, {7'h00, sw_mode, hund});
		check("switchover", 9'h002, {7'h00, sw_en, sw_hi});
		check("pins", 9'h000, {2'h0, irq_sel, clk_sel, cap_en});
		ef = 8'h00;
		rd_exp(ADDR_FLAGS, ef);
		for (int i = 0; i < 8; i++) begin
			pulse(8'h01 << i, 1'b0, 5'h00);
			ef = ef | (8'h01 << i);
			rd_exp(ADDR_FLAGS, ef);
			check("flags_o", {1'b0, ef}, {1'b0, flags_o});
			check("event_monitor", {8'h00, |ef}, {8'h00, ev_o});
		end
		rd_exp(ADDR_MINUTES, 8'haa);
		for (int i = 7; i >= 0; i--) begin
			wr_exp(ADDR_FLAGS, ~(8'h01 << i), 8'h00);
			ef = ef & ~(8'h01 << i);
			rd_exp(ADDR_FLAGS, ef);
		end
		rd_exp(ADDR_MINUTES, 8'h2a);
		repeat (6) begin
			lf = lfsr_next(lf);
			pulse(lf[7:0], 1'b0, 5'h00);
			ef = ef | lf[7:0];
			lf = lfsr_next(lf);
			wr_exp(ADDR_FLAGS, lf[7:0], 8'h00);
			ef = ef & lf[7:0];
			rd_exp(ADDR_FLAGS, ef);
			check("flags_o", {1'b0, ef}, {1'b0, flags_o});
			check("event_monitor", {8'h00, |ef}, {8'h00, ev_o});
		end
		pulse(8'h5a, 1'b1, 5'd0);
		pulse(8'hc3, 1'b1, 5'd17);
		pulse(8'h00, 1'b0, 5'd0);
		ef = ef | 8'hdb;
		rd_exp(ADDR_TS_FIRST, 8'h5a);
		rd_exp(ADDR_TS_LAST, 8'hc3);
		wr_exp(ADDR_RESET, CMD_CAPTURE_CLEAR, 8'h01);
		rd_exp(ADDR_TS_FIRST, 8'h00);
		rd_exp(ADDR_TS_LAST, 8'h00);
		// Counting is not modelled here, so the halt before a prescaler clear is not needed
		for (int i = 0; i < 7; i++) wr_exp(ADDR_RESET, cmd[i], code[i]);
		rd_exp(8'h40, 8'h00);
		rd_exp(ADDR_FLAGS, ef);
		repeat (4) @(posedge clk_i);
		rstn_i <= 1'b0;
		q.push_back({1'b0, 8'h0b});
		repeat (2) @(posedge clk_i);
		rstn_i <= 1'b1;
		// Let the power-on strobe retire first, notes are taken in order
		repeat (6) @(posedge clk_i);
		rd_exp(ADDR_FLAGS, 8'h00);
		repeat (10) @(posedge clk_i);
		check("notes_left", 9'h000, 9'(q.size()));
		print_verdict();
	end
endmodule : testbench
`default_nettype wire
